// ===== bsl_top.sv
// How it works
// - capture five strap levels at system reset release
// - latched straps hold until the next system reset or presetn release
// - one readback register shows all five bits
// - weak pulls during reset, per pin direction
// - pins return to normal use after capture
// - supply strap: 0 is 3.3 V, 1 is 1.8 V
// - boot select 1 flash; 0 with qualifier 0 download
// - log strap 1 enables boot console log
// - log and edge straps pick sdio edges
// - firmware may override rail and sdio edges
module bsl_top
  import bsl_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [bsl_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      por_rst,
  input  wire logic                      rtc_wdt_rst,
  input  wire logic                      brownout_rst,
  input  wire logic                      supply_voltage_strap_pin_i,
  output logic                           supply_voltage_strap_pin_o,
  output logic                           supply_voltage_strap_pin_oe_n,
  output logic                           supply_voltage_strap_pin_pu_en,
  output logic                           supply_voltage_strap_pin_pd_en,
  input  wire logic                      boot_select_strap_pin_i,
  output logic                           boot_select_strap_pin_o,
  output logic                           boot_select_strap_pin_oe_n,
  output logic                           boot_select_strap_pin_pu_en,
  output logic                           boot_select_strap_pin_pd_en,
  input  wire logic                      download_qualifier_strap_pin_i,
  output logic                           download_qualifier_strap_pin_o,
  output logic                           download_qualifier_strap_pin_oe_n,
  output logic                           download_qualifier_strap_pin_pu_en,
  output logic                           download_qualifier_strap_pin_pd_en,
  input  wire logic                      log_and_timing_strap_pin_i,
  output logic                           log_and_timing_strap_pin_o,
  output logic                           log_and_timing_strap_pin_oe_n,
  output logic                           log_and_timing_strap_pin_pu_en,
  output logic                           log_and_timing_strap_pin_pd_en,
  input  wire logic                      sdio_edge_strap_pin_i,
  output logic                           sdio_edge_strap_pin_o,
  output logic                           sdio_edge_strap_pin_oe_n,
  output logic                           sdio_edge_strap_pin_pu_en,
  output logic                           sdio_edge_strap_pin_pd_en,
  input  wire logic [4:0]                func_out,
  input  wire logic [4:0]                func_oe_n,
  output logic      [4:0]                func_in,
  output logic                           flash_rail_1v8,
  output logic                           boot_from_flash,
  output logic                           boot_download,
  output logic                           boot_undefined,
  output logic                           console_log_en,
  output logic                           sdio_sample_rising,
  output logic                           sdio_output_rising,
  output logic                           straps_valid
);
  import bsl_pkg::*;

  // live pin levels gathered into one vector
  logic [4:0]  pin_in;
  // latched strap bits and pin mode
  logic [4:0]  strap_r;
  bsl_mode_t   mode_r;
  bsl_mode_t   mode_nxt;
  logic        valid_r;
  // cause of the last system reset that was captured
  logic [2:0]  cause_r;
  logic [2:0]  cause_hold_r;
  // firmware override bits
  logic [4:0]  ovr_r;
  // registered pin drive
  logic [4:0]  pin_o_r;
  logic [4:0]  pin_oe_n_r;
  logic [4:0]  pin_pu_r;
  logic [4:0]  pin_pd_r;
  logic [4:0]  func_in_r;
  // registered decoded settings
  logic [7:0]  dec_r;
  logic [7:0]  dec_nxt;
  // apb read path registers
  logic [31:0] prdata_r;
  logic        pslverr_r;

  // any of the three system reset sources is asserted
  wire         sys_rst_act = por_rst | rtc_wdt_rst | brownout_rst;
  // release moment: pins still in strap mode, reset just gone
  wire         capture = (mode_r == BSL_STRAP) & ~sys_rst_act;

  assign pin_in[BIT_SUPPLY]     = supply_voltage_strap_pin_i;
  assign pin_in[BIT_BOOT_SEL]   = boot_select_strap_pin_i;
  assign pin_in[BIT_DL_QUAL]    = download_qualifier_strap_pin_i;
  assign pin_in[BIT_LOG_TIMING] = log_and_timing_strap_pin_i;
  assign pin_in[BIT_SDIO_EDGE]  = sdio_edge_strap_pin_i;

  // pin mode sequencing: strap while reset is held, run after
  always_comb
  begin
    case (mode_r)
      BSL_STRAP:
      begin
        // leave strap mode once levels are caught
        mode_nxt = sys_rst_act ? BSL_STRAP : BSL_RUN;
      end
      BSL_RUN:
      begin
        // a new system reset returns pins to strapping
        mode_nxt = sys_rst_act ? BSL_STRAP : BSL_RUN;
      end
      default:
      begin
        mode_nxt = BSL_STRAP;
      end
    endcase
  end

  // mode register; power-on starts in strapping mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= BSL_STRAP;
    else
      mode_r <= mode_nxt;
  end

  // strap latch: written only when pins leave strap mode, at a system reset or presetn release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_r <= STRAP_RST_VAL;
      valid_r <= 1'b0;
    end
    else if (capture)
    begin
      strap_r <= pin_in;
      valid_r <= 1'b1;
    end
    // otherwise held, whatever the pins do later
  end

  // remember which sources held the reset, reported after capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause_hold_r <= 3'h0;
      cause_r      <= 3'h0;
    end
    else if (sys_rst_act)
    begin
      // accumulate sources for the whole reset interval
      cause_hold_r <= cause_hold_r | {brownout_rst, rtc_wdt_rst, por_rst};
    end
    else if (capture)
    begin
      cause_r      <= cause_hold_r;
      cause_hold_r <= 3'h0;
    end
  end

  // per pin muxing between strap pulls and the function
  genvar gi;
  generate
    for (gi = 0; gi < STRAP_W; gi++)
    begin : g_pin
      wire in_strap = (mode_nxt == BSL_STRAP);
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pin_pu_r[gi]   <= PULL_UP_MASK[gi];
          pin_pd_r[gi]   <= PULL_DN_MASK[gi];
          pin_oe_n_r[gi] <= 1'b1;
          pin_o_r[gi]    <= 1'b0;
        end
        else
        begin
          // weak pull only while strapping, never a drive
          pin_pu_r[gi]   <= in_strap & PULL_UP_MASK[gi];
          pin_pd_r[gi]   <= in_strap & PULL_DN_MASK[gi];
          // functional drive only once levels are latched
          pin_oe_n_r[gi] <= in_strap | func_oe_n[gi];
          pin_o_r[gi]    <= func_out[gi];
        end
      end
      // input seen by the function, quiet while strapping
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          func_in_r[gi] <= 1'b0;
        else
          func_in_r[gi] <= (mode_r == BSL_RUN) & pin_in[gi];
      end
    end
  endgenerate

  assign supply_voltage_strap_pin_o         = pin_o_r[BIT_SUPPLY];
  assign supply_voltage_strap_pin_oe_n      = pin_oe_n_r[BIT_SUPPLY];
  assign supply_voltage_strap_pin_pu_en     = pin_pu_r[BIT_SUPPLY];
  assign supply_voltage_strap_pin_pd_en     = pin_pd_r[BIT_SUPPLY];
  assign boot_select_strap_pin_o            = pin_o_r[BIT_BOOT_SEL];
  assign boot_select_strap_pin_oe_n         = pin_oe_n_r[BIT_BOOT_SEL];
  assign boot_select_strap_pin_pu_en        = pin_pu_r[BIT_BOOT_SEL];
  assign boot_select_strap_pin_pd_en        = pin_pd_r[BIT_BOOT_SEL];
  assign download_qualifier_strap_pin_o     = pin_o_r[BIT_DL_QUAL];
  assign download_qualifier_strap_pin_oe_n  = pin_oe_n_r[BIT_DL_QUAL];
  assign download_qualifier_strap_pin_pu_en = pin_pu_r[BIT_DL_QUAL];
  assign download_qualifier_strap_pin_pd_en = pin_pd_r[BIT_DL_QUAL];
  assign log_and_timing_strap_pin_o         = pin_o_r[BIT_LOG_TIMING];
  assign log_and_timing_strap_pin_oe_n      = pin_oe_n_r[BIT_LOG_TIMING];
  assign log_and_timing_strap_pin_pu_en     = pin_pu_r[BIT_LOG_TIMING];
  assign log_and_timing_strap_pin_pd_en     = pin_pd_r[BIT_LOG_TIMING];
  assign sdio_edge_strap_pin_o              = pin_o_r[BIT_SDIO_EDGE];
  assign sdio_edge_strap_pin_oe_n           = pin_oe_n_r[BIT_SDIO_EDGE];
  assign sdio_edge_strap_pin_pu_en          = pin_pu_r[BIT_SDIO_EDGE];
  assign sdio_edge_strap_pin_pd_en          = pin_pd_r[BIT_SDIO_EDGE];
  assign func_in                            = func_in_r;

  // decode from the latch only, overrides applied on top
  wire s_sup  = strap_r[BIT_SUPPLY];
  wire s_bsel = strap_r[BIT_BOOT_SEL];
  wire s_dlq  = strap_r[BIT_DL_QUAL];
  wire s_log  = strap_r[BIT_LOG_TIMING];
  wire s_edge = strap_r[BIT_SDIO_EDGE];

  // rail: strap 1 means 1.8 V unless firmware overrides
  wire rail_1v8 = ovr_r[OVR_VOLT_EN] ? ovr_r[OVR_VOLT_1V8] : s_sup;
  // boot source; select 1 ignores the qualifier
  wire b_flash  = s_bsel;
  wire b_dl     = ~s_bsel & ~s_dlq;
  wire b_undef  = ~s_bsel & s_dlq;
  // sample edge from log strap, output edge from edge strap
  wire smp_r    = ovr_r[OVR_SDIO_EN] ? ovr_r[OVR_SDIO_SMP_R] : s_log;
  wire out_r    = ovr_r[OVR_SDIO_EN] ? ovr_r[OVR_SDIO_OUT_R] : s_edge;

  always_comb
  begin
    dec_nxt                = 8'h00;
    dec_nxt[ST_RAIL_1V8]   = rail_1v8;
    dec_nxt[ST_BOOT_FLASH] = b_flash;
    dec_nxt[ST_BOOT_DL]    = b_dl;
    dec_nxt[ST_BOOT_UNDEF] = b_undef;
    dec_nxt[ST_LOG_EN]     = s_log;
    dec_nxt[ST_SDIO_SMP_R] = smp_r;
    dec_nxt[ST_SDIO_OUT_R] = out_r;
    dec_nxt[ST_VALID]      = valid_r;
  end

  // decoded settings leave through flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_r <= 8'h00;
    else
      dec_r <= dec_nxt;
  end

  assign flash_rail_1v8     = dec_r[ST_RAIL_1V8];
  assign boot_from_flash    = dec_r[ST_BOOT_FLASH];
  assign boot_download      = dec_r[ST_BOOT_DL];
  assign boot_undefined     = dec_r[ST_BOOT_UNDEF];
  assign console_log_en     = dec_r[ST_LOG_EN];
  assign sdio_sample_rising = dec_r[ST_SDIO_SMP_R];
  assign sdio_output_rising = dec_r[ST_SDIO_OUT_R];
  assign straps_valid       = dec_r[ST_VALID];

  // apb address decode
  wire hit_rb    = (paddr == OFF_STRAP_RB);
  wire hit_stat  = (paddr == OFF_BOOT_STAT);
  wire hit_ovr   = (paddr == OFF_OVR_CTRL);
  wire hit_any   = hit_rb | hit_stat | hit_ovr;
  wire setup_ph  = psel & ~penable;
  wire wr_ovr    = psel & penable & pwrite & hit_ovr;

  // read words, upper bits zero
  wire [31:0] rd_rb   = {27'h0, strap_r};
  wire [31:0] rd_stat = {21'h0, cause_r, dec_r};
  wire [31:0] rd_ovr  = {27'h0, ovr_r};
  wire [31:0] rd_mux  = hit_rb   ? rd_rb :
                        hit_stat ? rd_stat :
                        hit_ovr  ? rd_ovr : 32'h0;

  // override register, written in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovr_r <= OVR_RST_VAL;
    else if (wr_ovr)
      ovr_r <= pwdata[OVR_W-1:0];
  end

  // read data and error caught in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_r  <= pwrite ? 32'h0 : rd_mux;
      pslverr_r <= ~hit_any;
    end
  end

  // zero wait states; error only shown in the access phase
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = psel & penable & pslverr_r;

endmodule

// ===== bsl_pkg.sv
package bsl_pkg;

  // strap bit positions inside the readback word
  localparam int unsigned STRAP_W         = 5;
  localparam int unsigned BIT_SUPPLY      = 0;
  localparam int unsigned BIT_BOOT_SEL    = 1;
  localparam int unsigned BIT_DL_QUAL     = 2;
  localparam int unsigned BIT_LOG_TIMING  = 3;
  localparam int unsigned BIT_SDIO_EDGE   = 4;

  // weak pull direction per strap pin while reset is active
  localparam logic [4:0]  PULL_UP_MASK    = 5'h1A;
  localparam logic [4:0]  PULL_DN_MASK    = 5'h05;

  // latch contents before the first capture after presetn release
  localparam logic [4:0]  STRAP_RST_VAL   = 5'h1A;

  // apb map, byte addresses
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] OFF_STRAP_RB    = 12'h000;
  localparam logic [11:0] OFF_BOOT_STAT   = 12'h004;
  localparam logic [11:0] OFF_OVR_CTRL    = 12'h008;

  // boot status field positions
  localparam int unsigned ST_RAIL_1V8     = 0;
  localparam int unsigned ST_BOOT_FLASH   = 1;
  localparam int unsigned ST_BOOT_DL      = 2;
  localparam int unsigned ST_BOOT_UNDEF   = 3;
  localparam int unsigned ST_LOG_EN       = 4;
  localparam int unsigned ST_SDIO_SMP_R   = 5;
  localparam int unsigned ST_SDIO_OUT_R   = 6;
  localparam int unsigned ST_VALID        = 7;
  localparam int unsigned ST_CAUSE_POR    = 8;
  localparam int unsigned ST_CAUSE_WDT    = 9;
  localparam int unsigned ST_CAUSE_BOD    = 10;

  // override control field positions
  localparam int unsigned OVR_VOLT_EN     = 0;
  localparam int unsigned OVR_VOLT_1V8    = 1;
  localparam int unsigned OVR_SDIO_EN     = 2;
  localparam int unsigned OVR_SDIO_SMP_R  = 3;
  localparam int unsigned OVR_SDIO_OUT_R  = 4;
  localparam int unsigned OVR_W           = 5;
  localparam logic [4:0]  OVR_RST_VAL     = 5'h00;

  // pin mode: strapping (pulls on, no drive) or functional
  typedef enum logic {BSL_STRAP, BSL_RUN} bsl_mode_t;

endpackage

// ===== bsl_props.sv
module bsl_props
  import bsl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        por_rst,
  input wire logic        rtc_wdt_rst,
  input wire logic        brownout_rst,
  input wire logic        supply_voltage_strap_pin_i,
  input wire logic        supply_voltage_strap_pin_pd_en,
  input wire logic        boot_select_strap_pin_i,
  input wire logic        boot_select_strap_pin_pu_en,
  input wire logic        boot_select_strap_pin_pd_en,
  input wire logic        boot_select_strap_pin_oe_n,
  input wire logic        download_qualifier_strap_pin_i,
  input wire logic        log_and_timing_strap_pin_i,
  input wire logic        sdio_edge_strap_pin_i,
  input wire logic [4:0]  func_oe_n,
  input wire logic        boot_from_flash,
  input wire logic        boot_download,
  input wire logic        console_log_en,
  input wire logic        straps_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // any system reset source active
  logic       sysr;
  logic       sysr_q_r;
  logic       sysr_qq_r;
  logic [4:0] shadow_r;
  assign sysr = por_rst | rtc_wdt_rst | brownout_rst;
  // reference latch: pins start in strap mode, so capture waits for all sources low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sysr_q_r  <= 1'b1;
      sysr_qq_r <= 1'b1;
      shadow_r  <= STRAP_RST_VAL;
    end
    else
    begin
      sysr_q_r  <= sysr;
      sysr_qq_r <= sysr_q_r;
      if (sysr_q_r && !sysr)
        shadow_r <= {sdio_edge_strap_pin_i, log_and_timing_strap_pin_i,
          download_qualifier_strap_pin_i, boot_select_strap_pin_i, supply_voltage_strap_pin_i};
    end
  end
  AST_PULL_ON: assert property (sysr |=> boot_select_strap_pin_pu_en &&
    supply_voltage_strap_pin_pd_en && !boot_select_strap_pin_pd_en && boot_select_strap_pin_oe_n)
    else $error("pulls not on in system reset");
  AST_PULL_OFF: assert property (sysr_q_r && !sysr |=> !boot_select_strap_pin_pu_en &&
    !supply_voltage_strap_pin_pd_en && boot_select_strap_pin_oe_n == $past(func_oe_n[1]))
    else $error("pins not released after capture");
  AST_VALID: assert property (sysr_q_r && !sysr |-> ##2 straps_valid)
    else $error("straps not valid after capture");
  AST_READBACK: assert property (psel && !penable && !pwrite && paddr == OFF_STRAP_RB
    |=> prdata == {27'h0, $past(shadow_r)}) else $error("readback differs from latch");
  AST_FLASH: assert property (straps_valid |-> boot_from_flash == $past(shadow_r[1]) &&
    boot_download == ($past(shadow_r[2:1]) == 2'b00)) else $error("boot decode wrong");
  AST_LOG: assert property (straps_valid |-> console_log_en == $past(shadow_r[3]))
    else $error("log enable decode wrong");
  AST_HOLD: assert property (!sysr && !sysr_q_r && !sysr_qq_r && straps_valid
    |=> $stable(boot_from_flash) && $stable(console_log_en)) else $error("decode moved");
  AST_SLVERR: assert property (psel && penable |-> pslverr == (paddr != OFF_STRAP_RB &&
    paddr != OFF_BOOT_STAT && paddr != OFF_OVR_CTRL)) else $error("error flag wrong for address");
endmodule

// ===== bsl_pins.sv
module bsl_pins (
  input wire logic        clk,
  input wire logic [4:0]  pu,
  input wire logic [4:0]  pd,
  input wire logic [4:0]  oe_n,
  input wire logic [4:0]  o,
  input wire logic [4:0]  ext_en,
  input wire logic [4:0]  ext_val,
  output logic     [4:0]  lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // floating pins wander so a missing pull never reads a lucky value
  logic [4:0] tog_r = 5'h15;
  always_ff @(posedge clk)
    tog_r <= ~tog_r;
  // wire level: device drive, then board drive, then weak pulls
  always_comb
  begin
    for (int i = 0; i < 5; i++)
      lvl[i] = !oe_n[i] ? o[i] : ext_en[i] ? ext_val[i] :
        pu[i] ? 1'b1 : pd[i] ? 1'b0 : tog_r[i];
  end
endmodule

// ===== testbench.sv
module testbench
  import bsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [2:0]  src = 0;
  logic [4:0]  fo = 0, foe = 5'h1F, ee = 0, ev = 0, pu, pd, oe, o, lvl, s, v, en, fi;
  int          num_errors = 0, n_checks = 0, seed = 32'h7335;
  initial forever #4 pclk = ~pclk;
  bsl_top u_bsl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .por_rst(src[0]), .rtc_wdt_rst(src[1]), .brownout_rst(src[2]),
    .supply_voltage_strap_pin_i(lvl[0]), .supply_voltage_strap_pin_o(o[0]),
    .supply_voltage_strap_pin_oe_n(oe[0]), .supply_voltage_strap_pin_pu_en(pu[0]),
    .supply_voltage_strap_pin_pd_en(pd[0]), .boot_select_strap_pin_i(lvl[1]),
    .boot_select_strap_pin_o(o[1]), .boot_select_strap_pin_oe_n(oe[1]),
    .boot_select_strap_pin_pu_en(pu[1]), .boot_select_strap_pin_pd_en(pd[1]),
    .download_qualifier_strap_pin_i(lvl[2]), .download_qualifier_strap_pin_o(o[2]),
    .download_qualifier_strap_pin_oe_n(oe[2]), .download_qualifier_strap_pin_pu_en(pu[2]),
    .download_qualifier_strap_pin_pd_en(pd[2]), .log_and_timing_strap_pin_i(lvl[3]),
    .log_and_timing_strap_pin_o(o[3]), .log_and_timing_strap_pin_oe_n(oe[3]),
    .log_and_timing_strap_pin_pu_en(pu[3]), .log_and_timing_strap_pin_pd_en(pd[3]),
    .sdio_edge_strap_pin_i(lvl[4]), .sdio_edge_strap_pin_o(o[4]),
    .sdio_edge_strap_pin_oe_n(oe[4]), .sdio_edge_strap_pin_pu_en(pu[4]),
    .sdio_edge_strap_pin_pd_en(pd[4]), .func_out(fo), .func_oe_n(foe), .func_in(fi),
    .flash_rail_1v8(), .boot_from_flash(), .boot_download(), .boot_undefined(),
    .console_log_en(), .sdio_sample_rising(), .sdio_output_rising(), .straps_valid());
  bsl_pins u_bsl_pins (.clk(pclk), .pu(pu), .pd(pd), .oe_n(oe), .o(o), .ext_en(ee),
    .ext_val(ev), .lvl(lvl));
  // one apb transfer, result left in rd and er
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected status word from straps, overrides and reset cause
  function automatic logic [31:0] stat(input logic [4:0] s, input logic [4:0] v,
    input logic [2:0] c);
    stat = {21'h0, c, 1'b1, v[2] ? v[4] : s[4], v[2] ? v[3] : s[3], s[3], ~s[1] & s[2],
      ~s[1] & ~s[2], s[1], v[0] ? v[1] : s[0]};
  endfunction
  task automatic summarize();
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_STRAP_RB, 0); `CHK(rd, 32'h1A)
    for (int i = 0; i < 24; i++)
    begin
      // first eight fully driven, covering every boot and sdio code
      en = i < 8 ? 5'h1F : 5'($random(seed));
      v  = i < 8 ? {i[0], i[1], i[0], i[2], i[1]} : 5'($random(seed));
      s  = (en & v) | (~en & 5'h1A);
      ee <= en;
      ev <= v;
      fo <= 5'($random(seed));
      foe <= 5'($random(seed));
      @(posedge pclk);
      src <= 3'b001 << (i % 3);
      repeat (1 + i % 4) @(posedge pclk);
      src <= 3'b000;
      repeat (3) @(posedge pclk);
      apb(0, OFF_STRAP_RB, 0); `CHK(rd, {27'h0, s})
      apb(0, OFF_BOOT_STAT, 0); `CHK(rd, stat(s, 5'h00, 3'(1 << (i % 3))))
      // live pins move, read-only write attempted: latch must not follow
      ev <= ~v;
      ee <= 5'h1F;
      apb(1, OFF_STRAP_RB, $random(seed));
      apb(0, OFF_STRAP_RB, 0); `CHK(rd, {27'h0, s})
      v = 5'($random(seed));
      apb(1, OFF_OVR_CTRL, {27'h0, v});
      apb(0, OFF_OVR_CTRL, 0); `CHK(rd, {27'h0, v})
      apb(0, OFF_BOOT_STAT, 0); `CHK(rd, stat(s, v, 3'(1 << (i % 3))))
      apb(1, OFF_OVR_CTRL, 0);
    end
    apb(0, 12'h00C, 0); `CHK({er, rd}, 33'h100000000)
    // power cycle in mid-run recaptures at release
    ev <= 5'h05;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_STRAP_RB, 0); `CHK(rd, 32'h05)
    // pins back in functional use: own drive where enabled, board level elsewhere
    `CHK(fi, (~foe & fo) | (foe & 5'h05))
    summarize();
  end
endmodule
bind bsl_top bsl_props u_bsl_props (.*);
